// >>> logic/io_cond.v
// Top of the configurable discrete I/O conditioning block with APB registers.
// Assumes vfunc_out comes from logic on pclk; in_pin comes from outside.
`timescale 1ns/1ns
`default_nettype none
`include "io_cond_defs.vh"
module io_cond #(
   parameter TICK_CYCLES = `TICK_US * 1000 / `CLK_PERIOD_NS
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:0] in_pin,
   output wire [15:0] vfunc_in,
   input wire [15:0] vfunc_out,
   output wire [3:0] out_pin
);
   // ==========================================
   // Constants
   // Ticks in one millisecond, for the fixed chopping patterns
   localparam integer TICKS_PER_MS = 1000 / `TICK_US;
   // Last prescaler count; cut to the 16-bit prescaler on purpose,
   // so a TICK_CYCLES above 65536 is not supported
   localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
   localparam [15:0] TICK_LAST = TICK_LAST_W[15:0];

   // ==========================================
   // Register storage
   reg [31:0] in_cfg_q [0:3]; // Input polarity, toggle, route
   reg [31:0] out_cfg_q [0:3]; // Output route and stage selects
   reg [15:0] on_dly_q [0:3]; // On-delay counts
   reg [15:0] off_dly_q [0:3]; // Off-delay counts
   reg [15:0] hold_q [0:3]; // Chopping full-on hold counts
   reg [31:0] man_time_q; // Manual chopping off and on ticks
   reg [31:0] prdata_q; // Read data
   reg pready_q; // Access phase completion
   reg pslverr_q; // Unmapped access flag
   reg [15:0] tick_ctr_q; // Prescaler
   reg tick_q; // 100 us pulse
   reg [15:0] vin_q; // Virtual input area
   reg [3:0] slot_q; // Physical output area
   wire [3:0] phys_in; // Physical input area
   wire [3:0] pol_out; // Polarity results of output chains
   wire [3:0] chop_out; // Chopping results, registered
   wire [1:0] port; // Port within a group
   wire acc_end; // Completing access edge
   integer i; // Reset loop index
   integer k; // Routing loop index

   assign port = paddr[3:2];
   assign acc_end = psel & penable & pready_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign vfunc_in = vin_q;
   assign out_pin = chop_out;

   // ==========================================
   // Address decode
   function mapped;
      input [7:0] a;
      input wr;
      begin
         mapped = (a[1:0] == 2'b00) &&
            ((a < `OFF_MAN_TIME) || (a == `OFF_MAN_TIME) ||
            ((a == `OFF_STATUS) && !wr));
      end
   endfunction

   // Read data for a word
   function [31:0] rd_word;
      input [7:0] a;
      input [1:0] p;
      begin
         rd_word = 32'h0000_0000;
         case (a[7:4])
            4'h0: rd_word = in_cfg_q[p];
            4'h1: rd_word = out_cfg_q[p];
            4'h2: rd_word = {16'h0000, on_dly_q[p]};
            4'h3: rd_word = {16'h0000, off_dly_q[p]};
            4'h4: rd_word = {16'h0000, hold_q[p]};
            4'h5: begin
               if (a == `OFF_MAN_TIME) begin
                  rd_word = man_time_q;
               end else begin
                  // Block state: input area, pins, virtual inputs
                  rd_word = {8'h00, vin_q, chop_out, phys_in};
               end
            end
            default: rd_word = 32'h0000_0000;
         endcase
      end
   endfunction

   // ==========================================
   // APB slave: one wait state, writes land at the completing edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         // Ready rises for one cycle in the access phase
         pready_q <= psel & penable & ~pready_q;
         // Error stands with ready only, never into the idle cycles after
         pslverr_q <= psel & penable & ~pready_q & ~mapped(paddr, pwrite);
         if (psel && penable && !pready_q) begin
            if (!pwrite && mapped(paddr, 1'b0)) begin
               prdata_q <= rd_word(paddr, port);
            end else begin
               prdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   // Register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < `N_OUT; i = i + 1) begin
            in_cfg_q[i] <= `CFG_RST;
            out_cfg_q[i] <= `CFG_RST;
            on_dly_q[i] <= 16'h0000;
            off_dly_q[i] <= 16'h0000;
            hold_q[i] <= 16'h0000;
         end
         man_time_q <= `MAN_TIME_RST;
      end else if (ce && acc_end && pwrite && !pslverr_q) begin
         case (paddr[7:4])
            4'h0: in_cfg_q[port] <= pwdata;
            4'h1: out_cfg_q[port] <= pwdata;
            4'h2: on_dly_q[port] <= pwdata[15:0];
            4'h3: off_dly_q[port] <= pwdata[15:0];
            4'h4: hold_q[port] <= pwdata[15:0];
            4'h5: begin
               if (paddr == `OFF_MAN_TIME) begin
                  man_time_q <= pwdata;
               end
            end
            default: begin
               // Nothing else is writable
            end
         endcase
      end
   end

   // ==========================================
   // Shared 100 us tick prescaler
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_ctr_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (ce) begin
         if (tick_ctr_q >= TICK_LAST) begin
            tick_ctr_q <= 16'h0000;
            tick_q <= 1'b1;
         end else begin
            tick_ctr_q <= tick_ctr_q + 16'h0001;
            tick_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // Input conditioning, one instance per pin
   genvar g;
   generate
      for (g = 0; g < `N_IN; g = g + 1) begin : gin
         in_cond u_in (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .pin(in_pin[g]),
            .pol_rev(in_cfg_q[g][`IN_POL]),
            .tog_en(in_cfg_q[g][`IN_TOG]),
            .cond_out(phys_in[g])
         );
      end
   endgenerate

   // Route physical inputs to virtual inputs and virtual outputs to slots
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vin_q <= 16'h0000;
         slot_q <= 4'h0;
      end else if (ce) begin
         for (k = 0; k < `N_VFUNC; k = k + 1) begin
            vin_q[k] <= |(phys_in & {
               in_cfg_q[3][`IN_SEL_LO+3:`IN_SEL_LO] == k[3:0],
               in_cfg_q[2][`IN_SEL_LO+3:`IN_SEL_LO] == k[3:0],
               in_cfg_q[1][`IN_SEL_LO+3:`IN_SEL_LO] == k[3:0],
               in_cfg_q[0][`IN_SEL_LO+3:`IN_SEL_LO] == k[3:0]});
         end
         for (k = 0; k < `N_OUT; k = k + 1) begin
            slot_q[k] <= vfunc_out[out_cfg_q[k][`OUT_SEL_LO+3:`OUT_SEL_LO]];
         end
      end
   end

   // ==========================================
   // Fixed pattern on/off times in ms
   function [7:0] pat_ms;
      input [3:0] mode;
      input on_ph;
      begin
         case (mode)
            4'h1: pat_ms = on_ph ? 8'h08 : 8'h04;
            4'h2: pat_ms = on_ph ? 8'h04 : 8'h02;
            4'h3: pat_ms = on_ph ? 8'h04 : 8'h04;
            4'h4: pat_ms = on_ph ? 8'h02 : 8'h02;
            4'h5: pat_ms = on_ph ? 8'h02 : 8'h04;
            4'h6: pat_ms = on_ph ? 8'h02 : 8'h0A;
            4'h7: pat_ms = on_ph ? 8'h02 : 8'h16;
            default: pat_ms = 8'h01;
         endcase
      end
   endfunction

   // ==========================================
   // Output chains: stages, then chopping per slot
   generate
      for (g = 0; g < `N_OUT; g = g + 1) begin : gout
         reg [15:0] hold_ctr_q; // Ticks of the full-on hold
         reg [15:0] ph_ctr_q; // Ticks in the current phase
         reg phase_q; // High while in the on phase
         reg pin_q; // Pin drive
         reg [15:0] ph_len; // Length of the current phase
         reg pin_d; // Next pin drive
         wire [3:0] mode; // Chopping selection
         wire [31:0] pat_full; // Pattern length of the current phase in ticks
         wire in_hold; // Full-on hold still running

         assign mode = out_cfg_q[g][`OUT_CHOP_LO+3:`OUT_CHOP_LO];
         assign pat_full = pat_ms(mode, phase_q) * TICKS_PER_MS;
         assign in_hold = hold_ctr_q < hold_q[g];
         assign chop_out[g] = pin_q;

         out_cond u_out (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .tick(tick_q),
            .sig_in(slot_q[g]),
            .tog_en(out_cfg_q[g][`OUT_TOG]),
            .on_en(out_cfg_q[g][`OUT_ON_EN]),
            .off_en(out_cfg_q[g][`OUT_OFF_EN]),
            .pol_rev(out_cfg_q[g][`OUT_POL]),
            .on_cnt(on_dly_q[g]),
            .off_cnt(off_dly_q[g]),
            .sig_out(pol_out[g])
         );

         // Phase length: manual times or a fixed pattern
         always @* begin
            if (mode == `CHOP_MANUAL) begin
               ph_len = phase_q ? man_time_q[15:0] : man_time_q[31:16];
            end else begin
               ph_len = pat_full[15:0];
            end
            if (mode == `CHOP_FULL || !pol_out[g]) begin
               pin_d = pol_out[g];
            end else if (in_hold) begin
               pin_d = 1'b1;
            end else begin
               pin_d = phase_q;
            end
         end

         // Chopping counters
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hold_ctr_q <= 16'h0000;
               ph_ctr_q <= 16'h0000;
               phase_q <= 1'b1;
               pin_q <= 1'b0;
            end else if (ce) begin
               pin_q <= pin_d;
               if (mode == `CHOP_FULL || !pol_out[g]) begin
                  // Restart the hold each time the signal asserts
                  hold_ctr_q <= 16'h0000;
                  ph_ctr_q <= 16'h0000;
                  phase_q <= 1'b1;
               end else if (tick_q) begin
                  if (in_hold) begin
                     hold_ctr_q <= hold_ctr_q + 16'h0001;
                  end else if (ph_ctr_q + 16'h0001 >= ph_len) begin
                     ph_ctr_q <= 16'h0000;
                     phase_q <= ~phase_q;
                  end else begin
                     ph_ctr_q <= ph_ctr_q + 16'h0001;
                  end
               end
            end
         end
      end
   endgenerate
endmodule // io_cond
`default_nettype wire

// >>> logic/io_cond_defs.vh
// Constants for the configurable discrete I/O conditioning block.
// Assumes the includer uses byte addresses on an APB bus with 32-bit data.
`ifndef IO_COND_DEFS_VH
`define IO_COND_DEFS_VH
// ==========================================
// Sizes
`define N_IN 4
`define N_OUT 4
`define N_VFUNC 16
// ==========================================
// Register byte offsets (one word per port, ports in ascending words)
`define OFF_IN_CFG 8'h00
`define OFF_OUT_CFG 8'h10
`define OFF_ON_DLY 8'h20
`define OFF_OFF_DLY 8'h30
`define OFF_CHOP_HOLD 8'h40
`define OFF_MAN_TIME 8'h50
`define OFF_STATUS 8'h54
// ==========================================
// Input config fields
`define IN_POL 0
`define IN_TOG 1
`define IN_SEL_LO 4
// Output config fields
`define OUT_SEL_LO 0
`define OUT_TOG 4
`define OUT_ON_EN 5
`define OUT_OFF_EN 6
`define OUT_POL 7
`define OUT_CHOP_LO 8
// Chopping codes: 1..7 are fixed patterns
`define CHOP_FULL 4'h0
`define CHOP_MANUAL 4'h8
// ==========================================
// Reset values
`define CFG_RST 32'h0000_0000
`define MAN_TIME_RST 32'h0014_0014
// ==========================================
// Timing
`define TICK_US 100
`define CLK_PERIOD_NS 4
`endif

// >>> logic/in_cond.v
// One physical input: pin synchroniser, polarity stage, toggle stage.
// Assumes the pin is asynchronous to pclk and tick-free (no timing here).
`timescale 1ns/1ns
`default_nettype none
module in_cond (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire pin,
   input wire pol_rev,
   input wire tog_en,
   output wire cond_out
);
   reg sync1_q; // First synchroniser stage, read only by sync2_q
   reg sync2_q; // Synchronised pin level
   reg prev_q; // Polarity result of last cycle, for edge detect
   reg tog_q; // Toggle state
   reg out_q; // Conditioned result
   wire pol_sig; // Polarity stage result
   wire cond_d; // Behaviour stage result

   assign pol_sig = sync2_q ^ pol_rev;
   assign cond_d = tog_en ? tog_q : pol_sig;
   assign cond_out = out_q;

   // ==========================================
   // Synchroniser, toggle and output register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         tog_q <= 1'b0;
         out_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         prev_q <= pol_sig;
         // Flip on each rising edge of the polarity result; held off while
         // toggling is not selected, so it always starts from off
         if (!tog_en) begin
            tog_q <= 1'b0;
         end else if (pol_sig && !prev_q) begin
            tog_q <= ~tog_q;
         end
         out_q <= cond_d;
      end
   end
endmodule // in_cond
`default_nettype wire

// >>> logic/out_cond.v
// One output slot: toggle, on-delay, off-delay and polarity stages.
// Assumes tick is a one-cycle pulse every 100 us on pclk.
`timescale 1ns/1ns
`default_nettype none
module out_cond (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire tick,
   input wire sig_in,
   input wire tog_en,
   input wire on_en,
   input wire off_en,
   input wire pol_rev,
   input wire [15:0] on_cnt,
   input wire [15:0] off_cnt,
   output wire sig_out
);
   reg prev_q; // Last input, for edge detect
   reg tog_q; // Toggle state
   reg [15:0] on_ctr_q; // Ticks since stage input rose
   reg [15:0] off_ctr_q; // Ticks since stage input fell
   reg arm_q; // Off-delay extension armed
   reg out_q; // Polarity result
   wire a_sig; // Behaviour stage result
   wire b_sig; // On-delay result
   wire c_sig; // Off-delay result
   wire on_done; // On-delay elapsed
   wire off_live; // Off-delay still extending

   assign a_sig = tog_en ? tog_q : sig_in;
   assign on_done = (on_ctr_q >= on_cnt);
   assign b_sig = on_en ? (a_sig & on_done) : a_sig;
   assign off_live = arm_q & (off_ctr_q < off_cnt);
   assign c_sig = off_en ? (b_sig | off_live) : b_sig;
   assign sig_out = out_q;

   // ==========================================
   // Stage state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
         tog_q <= 1'b0;
         on_ctr_q <= 16'h0000;
         off_ctr_q <= 16'h0000;
         arm_q <= 1'b0;
         out_q <= 1'b0;
      end else if (ce) begin
         prev_q <= sig_in;
         // Toggle starts off and turns on at the first rising edge; edges
         // seen while toggling is not selected leave no state behind
         if (!tog_en) begin
            tog_q <= 1'b0;
         end else if (sig_in && !prev_q) begin
            tog_q <= ~tog_q;
         end
         // On-delay counts ticks while the stage input stays high
         if (!a_sig) begin
            on_ctr_q <= 16'h0000;
         end else if (tick && !on_done) begin
            on_ctr_q <= on_ctr_q + 16'h0001;
         end
         // Off-delay counts ticks after the high period ends
         if (b_sig) begin
            off_ctr_q <= 16'h0000;
            arm_q <= 1'b1;
         end else if (!off_live) begin
            arm_q <= 1'b0;
         end else if (tick) begin
            off_ctr_q <= off_ctr_q + 16'h0001;
         end
         out_q <= c_sig ^ pol_rev;
      end
   end
endmodule // out_cond
`default_nettype wire

// >>> tb/io_cond_chk.sv
// Checker for io_cond: APB answer timing, refusals and start-up quiet.
// Assumes it is bound to io_cond and sees only the top's ports.
`timescale 1ns/1ns
`default_nettype none
module io_cond_chk #(
   parameter TICK_CYCLES = 25000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] vfunc_in,
   input wire logic [3:0] out_pin
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========================================
   // Bus answer
   property p_one_wait;
      $rose(penable) && psel && ce |-> !pready ##1 pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer not after one wait state");
   property p_pulse;
      pready && ce |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_in_access;
      pready |-> psel && penable;
   endproperty
   a_in_access: assert property (p_in_access) else $error("ready outside access phase");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   // ==========================================
   // Refusals and the map
   property p_ro_status;
      pready && pwrite && paddr == 8'h54 |-> pslverr;
   endproperty
   a_ro_status: assert property (p_ro_status) else $error("status write accepted");
   property p_misalign;
      pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0;
   endproperty
   a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
   property p_map_ok;
      pready && paddr[1:0] == 2'h0 && paddr < 8'h54 |-> !pslverr;
   endproperty
   a_map_ok: assert property (p_map_ok) else $error("mapped access refused");
   property p_unmapped;
      pready && paddr > 8'h54 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
   property p_status_view;
      pready && !pwrite && paddr == 8'h54 |-> prdata[23:8] == vfunc_in || prdata[23:8] == $past(vfunc_in);
   endproperty
   a_status_view: assert property (p_status_view) else $error("status disagrees with inputs");
   // Conditioned signals start off after reset
   property p_reset_quiet;
      $rose(presetn) |-> (out_pin == 4'h0 && vfunc_in == 16'h0) [*2];
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not off after reset");
   c_status: cover property (pready && !pwrite && paddr == 8'h54);
   c_refused: cover property (pready && pslverr);
   c_pin_on: cover property ($rose(out_pin[0]));
endmodule // io_cond_chk
bind io_cond io_cond_chk #(.TICK_CYCLES(TICK_CYCLES)) i_io_cond_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .vfunc_in(vfunc_in), .out_pin(out_pin));
`default_nettype wire

// >>> tb/field_side.sv
// Model of the switches and machine function logic outside the block.
// Assumes commands from the bench; levels settle one clock later.
`timescale 1ns/1ns
`default_nettype none
module field_side (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] sw_cmd,
   input wire logic [15:0] func_cmd,
   output logic [3:0] sw_pins,
   output logic [15:0] func_lines
);
   // Contacts and function lines are quiet in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_pins <= 4'h0;
         func_lines <= 16'h0;
      end else begin
         sw_pins <= sw_cmd;
         func_lines <= func_cmd;
      end
   end
endmodule // field_side
`default_nettype wire

// >>> tb/tb_io_cond.sv
// Testbench for io_cond: registers, input and output conditioning chains.
// Assumes a short tick prescaler and the field_side model on the pins.
`timescale 1ns/1ns
`default_nettype none
`include "io_cond_defs.vh"
module tb_io_cond;
   localparam int TK = 10; // Clock cycles per tick in this run
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] in_pin, out_pin, sw_cmd;
   logic [15:0] vfunc_in, vfunc_out, func_cmd;
   int error_cnt, comparisons, cyc;
   io_cond #(.TICK_CYCLES(TK)) i_io_cond (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_pin(in_pin), .vfunc_in(vfunc_in), .vfunc_out(vfunc_out), .out_pin(out_pin));
   field_side i_field_side (.pclk(pclk), .presetn(presetn), .sw_cmd(sw_cmd), .func_cmd(func_cmd),
      .sw_pins(in_pin), .func_lines(vfunc_out));
   // ==========================================
   // Clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ==========================================
   // Helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One transfer: setup, access until ready, then one idle cycle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check(pready, 1'b1, "no answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      check(er, 1'b0, "write refused");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check(rd, exp, "read data");
      check(er, e, "read error flag");
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      rdc(`OFF_IN_CFG, 32'h0, 1'b0);
      rdc(8'h1C, 32'h0, 1'b0);
      rdc(`OFF_MAN_TIME, `MAN_TIME_RST, 1'b0);
      rdc(8'h58, 32'h0, 1'b1);
      rdc(8'h02, 32'h0, 1'b1);
      apb(1'b1, `OFF_STATUS, 32'hFFFF_FFFF);
      check(er, 1'b1, "status write");
      rdc(`OFF_STATUS, 32'h0, 1'b0);
      wr(8'h24, 32'h0000_ABCD);
      rdc(8'h24, 32'h0000_ABCD, 1'b0);
   endtask
   task automatic t_in_path;
      wr(`OFF_IN_CFG, 32'h0000_0050);
      sw_cmd <= 4'h1;
      cw(10);
      check(vfunc_in, 16'h0020, "input route");
      rdc(`OFF_STATUS, 32'h0000_2001, 1'b0);
      wr(`OFF_IN_CFG, 32'h0000_0051);
      cw(10);
      check(vfunc_in, 16'h0000, "input reversed");
      sw_cmd <= 4'h0;
      cw(10);
      check(vfunc_in, 16'h0020, "input reversed low");
   endtask
   task automatic t_in_tog;
      wr(8'h04, 32'h0000_0032);
      for (int i = 0; i < 3; i++) begin
         sw_cmd <= 4'h2;
         cw(10);
         sw_cmd <= 4'h0;
         cw(10);
         check(vfunc_in[3], i % 2 == 0, "input toggle");
      end
   endtask
   // Mid-run reset returns toggles and routes to off
   task automatic t_reset;
      presetn <= 1'b0;
      cw(2);
      presetn <= 1'b1;
      cw(2);
      check(vfunc_in, 16'h0000, "reset clears inputs");
      rdc(8'h04, 32'h0, 1'b0);
   endtask
   task automatic t_out_pol;
      wr(`OFF_OUT_CFG, 32'h0000_0007);
      func_cmd <= 16'h0080;
      cw(8);
      check(out_pin, 4'h1, "output route");
      ce <= 1'b0;
      func_cmd <= 16'h0000;
      cw(8);
      check(out_pin, 4'h1, "clock enable freeze");
      ce <= 1'b1;
      func_cmd <= 16'h0080;
      cw(8);
      check(out_pin, 4'h1, "clock enable resume");
      wr(`OFF_OUT_CFG, 32'h0000_0087);
      cw(8);
      check(out_pin, 4'h0, "output reversed");
      func_cmd <= 16'h0000;
      cw(8);
      check(out_pin, 4'h1, "output reversed low");
      wr(`OFF_OUT_CFG, 32'h0000_0017);
      for (int i = 0; i < 3; i++) begin
         func_cmd <= 16'h0080;
         cw(8);
         func_cmd <= 16'h0000;
         cw(8);
         check(out_pin[0], i % 2 == 0, "output toggle");
      end
   endtask
   task automatic t_delay;
      wr(`OFF_ON_DLY, 32'h4);
      wr(`OFF_OFF_DLY, 32'h4);
      wr(`OFF_OUT_CFG, 32'h0000_0027);
      func_cmd <= 16'h0080;
      cw(3 * TK);
      check(out_pin[0], 1'b0, "on-delay early");
      cw(3 * TK);
      check(out_pin[0], 1'b1, "on-delay late");
      func_cmd <= 16'h0000;
      cw(8);
      check(out_pin[0], 1'b0, "on-delay fall");
      wr(`OFF_OUT_CFG, 32'h0000_0047);
      func_cmd <= 16'h0080;
      cw(8);
      check(out_pin[0], 1'b1, "off-delay rise");
      func_cmd <= 16'h0000;
      cw(3 * TK);
      check(out_pin[0], 1'b1, "off-delay held");
      cw(3 * TK);
      check(out_pin[0], 1'b0, "off-delay end");
   endtask
   task automatic t_chop;
      int on_t[1:9] = '{80, 40, 40, 20, 20, 20, 20, 8, 10};
      int off_t[1:9] = '{40, 20, 40, 20, 40, 100, 220, 16, 10};
      wr(`OFF_MAN_TIME, 32'h0010_0008);
      wr(`OFF_CHOP_HOLD, 32'h1E);
      for (int c = 1; c <= 9; c++) begin
         wr(`OFF_OUT_CFG, {20'h0, c[3:0], 8'h07});
         func_cmd <= 16'h0080;
         cw(10 * TK);
         check(out_pin[0], 1'b1, "chop hold");
         cw((20 + on_t[c] + off_t[c] / 2) * TK);
         check(out_pin[0], 1'b0, "chop off phase");
         cw((off_t[c] / 2 + on_t[c] / 2) * TK);
         check(out_pin[0], 1'b1, "chop on phase");
         func_cmd <= 16'h0000;
         cw(8);
         check(out_pin[0], 1'b0, "chop stop");
      end
   endtask
   // ==========================================
   // Verdict
   task automatic summarize;
      $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence after a four-cycle reset
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      sw_cmd = 4'h0;
      ce = 1'b1;
      func_cmd = 16'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_in_path();
      t_in_tog();
      t_reset();
      t_out_pol();
      t_delay();
      t_chop();
      summarize();
   end
   // Cuts a hung run short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("unexpected at %0t: run too long", $time);
         summarize();
      end
   end
endmodule // tb_io_cond
`default_nettype wire
